// file: nfc_params.svh
// Function
// - Unlocked commands open with AA@555, 55@2AA
// - Single F0 write resets, leaves autoselect
// - Unlock, 90@555, then read manufacturer at X00
// - Device identifier read at X01, X0E, X0F
// - Program: unlock, A0@555, data at location
// - Buffer load: 25@block, count@block, data words
// - 29 at block address commits buffer
// - Unlock then F0@555 aborts buffered write
// - Unlock, 20 enters bypass; short program, erase
// - Bypass: 80,10 chip erase; 90,00 exits
// - B0 suspends block erase, 30 resumes
// - Unlock, 88@555 selects one-time region
// - Unlock, 90@555, 00 leaves one-time region
// - One-time region accesses stay inside region
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH

// ----------------------------------------
// Command addresses and codes
// ----------------------------------------
`define NFC_ADDR_UNLOCK1   24'h00_0555
`define NFC_ADDR_UNLOCK2   24'h00_02AA
`define NFC_ADDR_ANY       24'h00_0000
`define NFC_CODE_UNLOCK1   16'h00AA
`define NFC_CODE_UNLOCK2   16'h0055
`define NFC_CODE_RESET     16'h00F0
`define NFC_CODE_AUTOSEL   16'h0090
`define NFC_CODE_PROGRAM   16'h00A0
`define NFC_CODE_BUFLOAD   16'h0025
`define NFC_CODE_BUFCOMMIT 16'h0029
`define NFC_CODE_BYPASS    16'h0020
`define NFC_CODE_ERASE     16'h0080
`define NFC_CODE_CHIP      16'h0010
`define NFC_CODE_BLOCK     16'h0030
`define NFC_CODE_SUSPEND   16'h00B0
`define NFC_CODE_RESUME    16'h0030
`define NFC_CODE_OTP       16'h0088
`define NFC_CODE_EXIT      16'h0000

// ----------------------------------------
// Field positions and limits
// ----------------------------------------
`define NFC_BLOCK_MSB      23
`define NFC_BLOCK_LSB      16
`define NFC_OTP_LIMIT      24'h00_0100
`define NFC_SEQ_MAX        6

// ----------------------------------------
// Bus timing
// ----------------------------------------
`define NFC_CLK_NS         8
`define NFC_T_SETUP_NS     10
`define NFC_T_WP_NS        35
`define NFC_T_ACC_NS       80
`define NFC_T_HOLD_NS      10
`define NFC_SYNC_CYC       2
`define NFC_CYC_UP(t)      (((t) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// file: nfc_pkg.sv
package nfc_pkg;

	// ----------------------------------------
	// Host operations
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_RESET, OP_READ, OP_PROGRAM, OP_AUTOSELECT, OP_BUF_LOAD,
		OP_BUF_WORD, OP_BUF_COMMIT, OP_BUF_ABORT, OP_BYPASS_ENTER,
		OP_BYPASS_PROGRAM, OP_BYPASS_BLOCK_ERASE, OP_BYPASS_CHIP_ERASE,
		OP_BYPASS_EXIT, OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_SUSPEND,
		OP_RESUME, OP_OTP_ENTER, OP_OTP_EXIT
	} nfc_op_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		nfc_op_t     op;
		logic [23:0] addr;
		logic [15:0] data;
	} nfc_req_t;

	typedef struct packed {
		logic        isRead;
		logic [23:0] addr;
		logic [15:0] data;
	} nfc_step_t;

	typedef nfc_step_t [5:0] nfc_seq_t;

	typedef struct packed {
		logic        resetN;
		logic        ceN;
		logic        oeN;
		logic        weN;
		logic [23:0] addr;
		logic [15:0] dqOut;
		logic        dqOe;
	} nfc_pins_t;

endpackage

// file: nfc_bus_cycle.sv
`timescale 1ns/1ps
`include "nfc_params.svh"

module nfc_bus_cycle
	import nfc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Step request
	input  wire logic        go,
	input  wire nfc_step_t   step,
	output logic             done,
	output logic [15:0]      rdData,
	// Flash pins
	input  wire logic [15:0] dqIn,
	output nfc_pins_t        pins
);

	// ----------------------------------------
	// Timing counts, least times rounded up
	// ----------------------------------------
	localparam logic [7:0] SETUP_CYC = 8'(`NFC_CYC_UP(`NFC_T_SETUP_NS));
	localparam logic [7:0] WP_CYC    = 8'(`NFC_CYC_UP(`NFC_T_WP_NS));
	localparam logic [7:0] RD_CYC    =
		8'(`NFC_CYC_UP(`NFC_T_ACC_NS) + `NFC_SYNC_CYC);
	localparam logic [7:0] HOLD_CYC  = 8'(`NFC_CYC_UP(`NFC_T_HOLD_NS));

	typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} nfc_bstate_t;

	nfc_bstate_t state;
	logic [7:0]  cnt;
	logic [15:0] dqMeta;
	logic [15:0] dqSync;
	logic        cntZero;
	logic [7:0]  strobeLen;

	assign cntZero   = (cnt == 8'h00);
	assign strobeLen = step.isRead ? RD_CYC : WP_CYC;

	// ----------------------------------------
	// Data pins synchroniser
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dqMeta <= 16'h0000;
			dqSync <= 16'h0000;
		end
		else
		begin
			dqMeta <= dqIn;
			dqSync <= dqMeta;
		end
	end

	// ----------------------------------------
	// One bus cycle: setup, strobe, hold
	// ----------------------------------------
	// Read strobe covers access time plus the two sync stages
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state  <= B_IDLE;
			cnt    <= 8'h00;
			done   <= 1'b0;
			rdData <= 16'h0000;
			pins   <= '{resetN: 1'b1, ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
				addr: 24'h00_0000, dqOut: 16'h0000, dqOe: 1'b0};
		end
		else
		begin
			done <= 1'b0;
			unique case (state)
				B_IDLE:
					if (go)
					begin
						pins.ceN   <= 1'b0;
						pins.addr  <= step.addr;
						pins.dqOut <= step.data;
						pins.dqOe  <= !step.isRead;
						cnt        <= SETUP_CYC - 8'h01;
						state      <= B_SETUP;
					end
				B_SETUP:
					if (cntZero)
					begin
						pins.weN <= !pins.dqOe;
						pins.oeN <= pins.dqOe;
						cnt      <= strobeLen - 8'h01;
						state    <= B_STROBE;
					end
					else
						cnt <= cnt - 8'h01;
				B_STROBE:
					if (cntZero)
					begin
						pins.weN <= 1'b1;
						pins.oeN <= 1'b1;
						if (!pins.dqOe)
							rdData <= dqSync;
						cnt   <= HOLD_CYC - 8'h01;
						state <= B_HOLD;
					end
					else
						cnt <= cnt - 8'h01;
				B_HOLD:
					if (cntZero)
					begin
						pins.ceN  <= 1'b1;
						pins.dqOe <= 1'b0;
						done      <= 1'b1;
						state     <= B_IDLE;
					end
					else
						cnt <= cnt - 8'h01;
			endcase
		end
	end

endmodule // nfc_bus_cycle

// file: nfc_host.sv
`timescale 1ns/1ps
`include "nfc_params.svh"

module nfc_host
	import nfc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// User request port
	input  wire logic        reqValid,
	input  wire nfc_req_t    req,
	output logic             reqReady,
	output logic             reqDone,
	output logic             reqError,
	output logic [15:0]      readData,
	// Mode view
	output logic             inBypass,
	output logic             inAutoselect,
	output logic             inOtp,
	// Flash pins
	input  wire logic [15:0] flashDqIn,
	output nfc_pins_t        flashPins
);

	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} nfc_state_t;

	// ----------------------------------------
	// Sequence builder
	// ----------------------------------------
	function automatic nfc_step_t wr(input logic [23:0] a,
		input logic [15:0] d);
		wr = '{isRead: 1'b0, addr: a, data: d};
	endfunction

	function automatic nfc_step_t rd(input logic [23:0] a);
		rd = '{isRead: 1'b1, addr: a, data: 16'h0000};
	endfunction

	// Upper bits zero on command cycles, block address from top byte
	function automatic nfc_seq_t buildSeq(input nfc_req_t r);
		nfc_step_t u1;
		nfc_step_t u2;
		logic [23:0] ba;
		u1 = wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_UNLOCK1);
		u2 = wr(`NFC_ADDR_UNLOCK2, `NFC_CODE_UNLOCK2);
		ba = {r.addr[`NFC_BLOCK_MSB:`NFC_BLOCK_LSB], 16'h0000};
		buildSeq = '0;
		unique case (r.op)
			OP_RESET: buildSeq[0] = wr(`NFC_ADDR_ANY, `NFC_CODE_RESET);
			OP_READ: buildSeq[0] = rd(r.addr);
			OP_PROGRAM: buildSeq[3:0] = {wr(r.addr, r.data),
				wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_PROGRAM), u2, u1};
			OP_AUTOSELECT: buildSeq[3:0] = {rd(r.addr),
				wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_AUTOSEL), u2, u1};
			OP_BUF_LOAD: buildSeq[3:0] = {wr(ba, r.data),
				wr(ba, `NFC_CODE_BUFLOAD), u2, u1};
			OP_BUF_WORD: buildSeq[0] = wr(r.addr, r.data);
			OP_BUF_COMMIT: buildSeq[0] = wr(ba, `NFC_CODE_BUFCOMMIT);
			OP_BUF_ABORT: buildSeq[2:0] = {
				wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_RESET), u2, u1};
			OP_BYPASS_ENTER: buildSeq[2:0] = {
				wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_BYPASS), u2, u1};
			OP_BYPASS_PROGRAM: buildSeq[1:0] = {wr(r.addr, r.data),
				wr(`NFC_ADDR_ANY, `NFC_CODE_PROGRAM)};
			OP_BYPASS_BLOCK_ERASE: buildSeq[1:0] = {wr(ba, `NFC_CODE_BLOCK),
				wr(`NFC_ADDR_ANY, `NFC_CODE_ERASE)};
			OP_BYPASS_CHIP_ERASE: buildSeq[1:0] = {
				wr(`NFC_ADDR_ANY, `NFC_CODE_CHIP),
				wr(`NFC_ADDR_ANY, `NFC_CODE_ERASE)};
			OP_BYPASS_EXIT: buildSeq[1:0] = {wr(`NFC_ADDR_ANY, `NFC_CODE_EXIT),
				wr(`NFC_ADDR_ANY, `NFC_CODE_AUTOSEL)};
			OP_CHIP_ERASE: buildSeq = {wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_CHIP),
				u2, u1, wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_ERASE), u2, u1};
			OP_BLOCK_ERASE: buildSeq = {wr(ba, `NFC_CODE_BLOCK),
				u2, u1, wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_ERASE), u2, u1};
			OP_SUSPEND: buildSeq[0] = wr(`NFC_ADDR_ANY,
				`NFC_CODE_SUSPEND);
			OP_RESUME: buildSeq[0] = wr(`NFC_ADDR_ANY,
				`NFC_CODE_RESUME);
			OP_OTP_ENTER: buildSeq[2:0] = {
				wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_OTP), u2, u1};
			OP_OTP_EXIT: buildSeq[3:0] = {wr(`NFC_ADDR_ANY, `NFC_CODE_EXIT),
				wr(`NFC_ADDR_UNLOCK1, `NFC_CODE_AUTOSEL), u2, u1};
			default: buildSeq = '0;
		endcase
	endfunction

	function automatic logic [2:0] seqLen(input nfc_op_t op);
		unique case (op)
			OP_PROGRAM, OP_AUTOSELECT, OP_BUF_LOAD, OP_OTP_EXIT: seqLen = 3'd4;
			OP_BUF_ABORT, OP_BYPASS_ENTER, OP_OTP_ENTER: seqLen = 3'd3;
			OP_BYPASS_PROGRAM, OP_BYPASS_BLOCK_ERASE, OP_BYPASS_CHIP_ERASE,
			OP_BYPASS_EXIT: seqLen = 3'd2;
			OP_CHIP_ERASE, OP_BLOCK_ERASE: seqLen = 3'(`NFC_SEQ_MAX);
			default: seqLen = 3'd1;
		endcase
	endfunction

	// ----------------------------------------
	// Request legality
	// ----------------------------------------
	// Only defined sequences go out, so the flash never drops a half
	// command; bypass accepts only its short forms plus reads, suspend and resume.
	wire logic isBypassOp = (req.op == OP_BYPASS_PROGRAM)
		|| (req.op == OP_BYPASS_BLOCK_ERASE)
		|| (req.op == OP_BYPASS_CHIP_ERASE) || (req.op == OP_BYPASS_EXIT);
	wire logic bypassOk = inBypass ? (isBypassOp || req.op == OP_READ
		|| req.op == OP_SUSPEND || req.op == OP_RESUME) : !isBypassOp;
	wire logic otpAccess = (req.op == OP_READ) || (req.op == OP_PROGRAM);
	wire logic otpOk = !(inOtp && otpAccess
		&& req.addr >= `NFC_OTP_LIMIT);
	wire logic reqLegal = bypassOk && otpOk;
	wire logic take = reqReady && reqValid;

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	nfc_state_t  state;
	nfc_seq_t    seq;
	nfc_op_t     curOp;
	logic [2:0]  len;
	logic [2:0]  idx;
	logic        go;
	nfc_step_t   step;
	logic        cycDone;
	logic [15:0] cycData;
	wire logic   lastStep = (idx == len - 3'd1);

	nfc_bus_cycle u_cycle (
		.clock   (clock),
		.reset_n (reset_n),
		.go      (go),
		.step    (step),
		.done    (cycDone),
		.rdData  (cycData),
		.dqIn    (flashDqIn),
		.pins    (flashPins)
	);

	// Steps one bus cycle at a time, capturing read words
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state    <= S_IDLE;
			seq      <= '0;
			curOp    <= OP_RESET;
			len      <= 3'd1;
			idx      <= 3'd0;
			go       <= 1'b0;
			step     <= '0;
			reqReady <= 1'b1;
			reqDone  <= 1'b0;
			reqError <= 1'b0;
			readData <= 16'h0000;
		end
		else
		begin
			go       <= 1'b0;
			reqDone  <= 1'b0;
			reqError <= 1'b0;
			unique case (state)
				S_IDLE:
					if (take && reqLegal)
					begin
						seq      <= buildSeq(req);
						len      <= seqLen(req.op);
						curOp    <= req.op;
						idx      <= 3'd0;
						reqReady <= 1'b0;
						state    <= S_ISSUE;
					end
					else if (take)
						reqError <= 1'b1;
				S_ISSUE:
				begin
					step  <= seq[idx];
					go    <= 1'b1;
					state <= S_WAIT;
				end
				S_WAIT:
					if (cycDone)
					begin
						if (step.isRead)
							readData <= cycData;
						if (lastStep)
						begin
							reqDone  <= 1'b1;
							reqReady <= 1'b1;
							state    <= S_IDLE;
						end
						else
						begin
							idx   <= idx + 3'd1;
							state <= S_ISSUE;
						end
					end
			endcase
		end
	end

	// ----------------------------------------
	// Mode tracking
	// ----------------------------------------
	// Mirrors the flash's modes so requests are shaped correctly
	wire logic opEnd = (state == S_WAIT) && cycDone && lastStep;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			inBypass     <= 1'b0;
			inAutoselect <= 1'b0;
			inOtp        <= 1'b0;
		end
		else if (opEnd)
		begin
			if (curOp == OP_BYPASS_ENTER)
				inBypass <= 1'b1;
			else if (curOp == OP_BYPASS_EXIT)
				inBypass <= 1'b0;
			if (curOp == OP_AUTOSELECT)
				inAutoselect <= 1'b1;
			else if (curOp == OP_RESET)
				inAutoselect <= 1'b0;
			if (curOp == OP_OTP_ENTER)
				inOtp <= 1'b1;
			else if (curOp == OP_OTP_EXIT)
				inOtp <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_unlock_first;
		@(posedge clock) disable iff (!reset_n)
		go && idx == 3'd0 && (curOp == OP_PROGRAM || curOp == OP_OTP_ENTER)
		|-> step.addr == 24'h00_0555 && step.data == 16'h00AA;
	endproperty
	a_unlock_first: assert property (p_unlock_first)
		else $error("first unlock cycle wrong");

	property p_reset_code;
		@(posedge clock) disable iff (!reset_n)
		go && curOp == OP_RESET |-> step.data == 16'h00F0 && !step.isRead;
	endproperty
	a_reset_code: assert property (p_reset_code)
		else $error("reset command not F0");

	property p_autosel_read;
		@(posedge clock) disable iff (!reset_n)
		go && curOp == OP_AUTOSELECT && idx == 3'd3 |-> step.isRead;
	endproperty
	a_autosel_read: assert property (p_autosel_read)
		else $error("autoselect fourth cycle not a read");

	property p_program_code;
		@(posedge clock) disable iff (!reset_n)
		go && curOp == OP_PROGRAM && idx == 3'd2
		|-> step.data == 16'h00A0 && step.addr == 24'h00_0555;
	endproperty
	a_program_code: assert property (p_program_code)
		else $error("program command cycle wrong");

	property p_block_erase_last;
		@(posedge clock) disable iff (!reset_n)
		go && curOp == OP_BLOCK_ERASE && idx == 3'd5
		|-> step.data == 16'h0030 && step.addr[15:0] == 16'h0000;
	endproperty
	a_block_erase_last: assert property (p_block_erase_last)
		else $error("block erase final cycle wrong");

	property p_bypass_set;
		@(posedge clock) disable iff (!reset_n)
		opEnd && curOp == OP_BYPASS_ENTER |=> inBypass && reqDone;
	endproperty
	a_bypass_set: assert property (p_bypass_set)
		else $error("bypass flag not set");

	property p_otp_refuse;
		@(posedge clock) disable iff (!reset_n)
		take && inOtp && req.op == OP_READ && req.addr >= 24'h00_0100
		|=> reqError && state == S_IDLE;
	endproperty
	a_otp_refuse: assert property (p_otp_refuse)
		else $error("out of region access not refused");

	property p_strobes_apart;
		@(posedge clock) disable iff (!reset_n)
		!(!flashPins.weN && !flashPins.oeN);
	endproperty
	a_strobes_apart: assert property (p_strobes_apart)
		else $error("read and write strobes overlap");

	property p_step_done;
		@(posedge clock) disable iff (!reset_n)
		go |-> ##[4:20] cycDone;
	endproperty
	a_step_done: assert property (p_step_done)
		else $error("bus cycle did not finish");

	c_program: cover property (@(posedge clock) opEnd && curOp == OP_PROGRAM);
	c_erase: cover property (@(posedge clock)
		opEnd && curOp == OP_BLOCK_ERASE);
	c_autosel: cover property (@(posedge clock)
		opEnd && curOp == OP_AUTOSELECT);
	c_refuse: cover property (@(posedge clock) reqError);

endmodule // nfc_host

// file: nfc_flash_model.sv
`timescale 1ns/1ps

module nfc_flash_model
	import nfc_pkg::*;
#(
	parameter logic [15:0] MAKER = 16'h005A, // Arbitrary value
	parameter logic [15:0] PART1 = 16'h1101, // Arbitrary value
	parameter logic [15:0] PART2 = 16'h1102, // Arbitrary value
	parameter logic [15:0] PART3 = 16'h1103, // Arbitrary value
	parameter logic [15:0] IND   = 16'h0081,
	parameter logic [15:0] LOCK  = 16'h0001,
	parameter logic [7:0]  GUARD = 8'h12
)
(
	// Host pins
	input  wire nfc_pins_t   pins,
	// Data toward host
	output logic [15:0]      dq
);
	// ----------------------------------------
	// Array, modes and sequence state
	// ----------------------------------------
	logic [15:0] mem [logic [23:0]];
	logic [15:0] otpMem [logic [7:0]];
	logic [15:0] bufMem [logic [23:0]];
	logic [15:0] outWord = 16'hFFFF;
	logic [15:0] lastDq  = 16'h0000;
	logic [7:0]  d;
	logic [7:0]  blk;
	logic [7:0]  pend    = 8'h00;
	logic [7:0]  bufBlk  = 8'h00;
	logic [13:0] a;
	int          cnt     = 0;
	int          bufLeft = 0;
	logic        autoMode = 1'b0;
	logic        otp      = 1'b0;
	logic        bypass   = 1'b0;

	// Erase finishes at once, so the part is back in read mode at once
	task automatic eraseBlock(input logic [7:0] b);
		logic [23:0] q [$];
		foreach (mem[k])
			if (k[23:16] == b)
				q.push_back(k);
		foreach (q[i])
			mem.delete(q[i]);
	endtask

	// One command step, decoded on the low data byte only
	task automatic takeWrite();
		d = pins.dqOut[7:0];
		a = pins.addr[13:0];
		blk = pins.addr[23:16];
		if (bypass && pend != 8'h00)
		begin
			if (pend == 8'hA0)
				mem[pins.addr] = pins.dqOut;
			else if (pend == 8'h80 && d == 8'h30)
				eraseBlock(blk);
			else if (pend == 8'h80 && d == 8'h10)
				mem.delete();
			else if (pend == 8'h90 && d == 8'h00)
				bypass = 1'b0;
			pend = 8'h00;
		end
		else if (bypass)
			pend = (d inside {8'hA0, 8'h80, 8'h90}) ? d : 8'h00;
		else if (cnt == 3 && pend == 8'hA0)
		begin
			if (otp)
				otpMem[pins.addr[7:0]] = pins.dqOut;
			else
				mem[pins.addr] = pins.dqOut;
			cnt = 0;
		end
		else if (cnt == 3 && pend == 8'h25)
		begin
			bufLeft = int'(pins.dqOut);
			bufBlk = blk;
			bufMem.delete();
			cnt = 0;
		end
		else if (cnt == 0 && bufLeft > 0 && blk == bufBlk)
		begin
			bufMem[pins.addr] = pins.dqOut;
			bufLeft--;
		end
		else if (d == 8'hF0)
		begin
			cnt = 0;
			autoMode = 1'b0;
			bufLeft = 0;
			bufMem.delete();
		end
		else if (cnt == 0 && d == 8'h29 && blk == bufBlk)
		begin
			foreach (bufMem[k])
				mem[k] = bufMem[k];
			bufMem.delete();
		end
		else if (cnt == 0 && d inside {8'hB0, 8'h30})
			cnt = 0; // nothing left to pause
		else if (cnt == 0 || (cnt == 3 && pend == 8'h90 && d != 8'h00))
			cnt = (d == 8'hAA && a == 14'h0555) ? 1 : 0;
		else if (cnt == 1)
			cnt = (d == 8'h55 && a == 14'h02AA) ? 2 : 0;
		else if (cnt == 2)
		begin
			pend = d;
			cnt = (d == 8'h25 || a == 14'h0555) ? 3 : 0;
			if (d == 8'h90 && cnt == 3)
				autoMode = 1'b1;
			else if (d == 8'h20 || d == 8'h88)
			begin
				bypass = bypass | (d == 8'h20 && cnt == 3);
				otp = otp | (d == 8'h88 && cnt == 3);
				pend = 8'h00;
				cnt = 0;
			end
			else if (!(d inside {8'h25, 8'hA0, 8'h80}))
				cnt = 0;
		end
		else if (cnt == 3 && pend == 8'h90)
		begin
			otp = 1'b0;
			autoMode = 1'b0;
			cnt = 0;
		end
		else if (cnt == 3)
			cnt = (d == 8'hAA && a == 14'h0555) ? 4 : 0;
		else if (cnt == 4)
			cnt = (d == 8'h55 && a == 14'h02AA) ? 5 : 0;
		else
		begin
			if (d == 8'h10 && a == 14'h0555)
				mem.delete();
			else if (d == 8'h30)
				eraseBlock(blk);
			cnt = 0;
		end
	endtask

	// Write strobe release latches the step
	always @(posedge pins.weN)
		if (!pins.ceN)
			takeWrite();

	// Read source chosen as the output strobe falls
	always @(negedge pins.oeN)
		if (autoMode)
			case (pins.addr[7:0])
				8'h00: outWord = MAKER;
				8'h01: outWord = PART1;
				8'h0E: outWord = PART2;
				8'h0F: outWord = PART3;
				8'h02: outWord = 16'(pins.addr[23:16] == GUARD);
				8'h03: outWord = IND;
				8'h07: outWord = LOCK;
				default: outWord = 16'hFFFF;
			endcase
		else if (otp)
			outWord = otpMem.exists(pins.addr[7:0]) ?
				otpMem[pins.addr[7:0]] : 16'hFFFF;
		else
			outWord = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;

	// Released bus shows the inverse, so stale data never passes
	always @(posedge pins.oeN)
		lastDq <= outWord;
	assign dq = (!pins.ceN && !pins.oeN) ? outWord : ~lastDq;
endmodule // nfc_flash_model

// file: test_nfc_host.sv
`timescale 1ns/1ps

module test_nfc_host
	import nfc_pkg::*;
;
	typedef struct {
		nfc_op_t     op;
		logic [23:0] addr;
		logic [15:0] data;
	} nfc_row_t;

	localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value
	localparam logic [15:0] PART1 = 16'h1101; // Arbitrary value
	localparam logic [15:0] PART2 = 16'h1102; // Arbitrary value
	localparam logic [15:0] PART3 = 16'h1103; // Arbitrary value
	localparam logic [15:0] IND   = 16'h0081;
	localparam logic [15:0] LOCK  = 16'h0001;
	localparam logic [7:0]  GUARD = 8'h12;
	localparam int          N_ROWS = 44;

	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        reqValid = 1'b0;
	nfc_req_t    req = '0;
	logic        reqReady;
	logic        reqDone;
	logic        reqError;
	logic [15:0] readData;
	logic        inBypass;
	logic        inAutoselect;
	logic        inOtp;
	logic [15:0] flashDqIn;
	logic [15:0] modelDq;
	nfc_pins_t   flashPins;
	logic        gotErr;
	int          errorCnt = 0;
	int          nChecks = 0;

	// Reads carry the expected word in the data column
	nfc_row_t rows [N_ROWS] = '{
		'{OP_READ, 24'h00_1234, 16'hFFFF},
		'{OP_PROGRAM, 24'h00_1234, 16'hBEEF},
		'{OP_READ, 24'h00_1234, 16'hBEEF},
		'{OP_AUTOSELECT, 24'h00_0000, MAKER},
		'{OP_AUTOSELECT, 24'h00_0001, PART1},
		'{OP_AUTOSELECT, 24'h00_000E, PART2},
		'{OP_AUTOSELECT, 24'h00_000F, PART3},
		'{OP_AUTOSELECT, {GUARD, 16'h0002}, 16'h0001},
		'{OP_AUTOSELECT, 24'h13_0002, 16'h0000},
		'{OP_AUTOSELECT, 24'h00_0003, IND},
		'{OP_AUTOSELECT, 24'h00_0007, LOCK},
		'{OP_RESET, 24'h00_0000, 16'h0000},
		'{OP_READ, 24'h00_1234, 16'hBEEF},
		'{OP_BUF_LOAD, 24'h05_0000, 16'h0002},
		'{OP_BUF_WORD, 24'h05_0010, 16'h1111},
		'{OP_BUF_WORD, 24'h05_0011, 16'h2222},
		'{OP_BUF_COMMIT, 24'h05_0000, 16'h0000},
		'{OP_READ, 24'h05_0010, 16'h1111},
		'{OP_READ, 24'h05_0011, 16'h2222},
		'{OP_BUF_LOAD, 24'h05_0000, 16'h0002},
		'{OP_BUF_WORD, 24'h05_0020, 16'h3333},
		'{OP_BUF_ABORT, 24'h00_0000, 16'h0000},
		'{OP_READ, 24'h05_0020, 16'hFFFF},
		'{OP_BLOCK_ERASE, 24'h05_0000, 16'h0000},
		'{OP_READ, 24'h05_0010, 16'hFFFF},
		'{OP_SUSPEND, 24'h00_0000, 16'h0000},
		'{OP_RESUME, 24'h00_0000, 16'h0000},
		'{OP_OTP_ENTER, 24'h00_0000, 16'h0000},
		'{OP_PROGRAM, 24'h00_0080, 16'hC0DE},
		'{OP_READ, 24'h00_0080, 16'hC0DE},
		'{OP_OTP_EXIT, 24'h00_0000, 16'h0000},
		'{OP_READ, 24'h00_0080, 16'hFFFF},
		'{OP_PROGRAM, 24'h00_3000, 16'h4321},
		'{OP_READ, 24'h00_3000, 16'h4321},
		'{OP_CHIP_ERASE, 24'h00_0000, 16'h0000},
		'{OP_READ, 24'h00_3000, 16'hFFFF},
		'{OP_BYPASS_ENTER, 24'h00_0000, 16'h0000},
		'{OP_BYPASS_PROGRAM, 24'h06_0005, 16'h5A5A},
		'{OP_READ, 24'h06_0005, 16'h5A5A},
		'{OP_BYPASS_BLOCK_ERASE, 24'h06_0000, 16'h0000},
		'{OP_READ, 24'h06_0005, 16'hFFFF},
		'{OP_BYPASS_CHIP_ERASE, 24'h00_0000, 16'h0000},
		'{OP_BYPASS_EXIT, 24'h00_0000, 16'h0000},
		'{OP_READ, 24'h00_1234, 16'hFFFF}
	};

	// ----------------------------------------
	// Design, far side and data wire
	// ----------------------------------------
	nfc_host u_dut (
		.clock        (clock),
		.reset_n      (reset_n),
		.reqValid     (reqValid),
		.req          (req),
		.reqReady     (reqReady),
		.reqDone      (reqDone),
		.reqError     (reqError),
		.readData     (readData),
		.inBypass     (inBypass),
		.inAutoselect (inAutoselect),
		.inOtp        (inOtp),
		.flashDqIn    (flashDqIn),
		.flashPins    (flashPins)
	);

	nfc_flash_model #(
		.MAKER (MAKER),
		.PART1 (PART1),
		.PART2 (PART2),
		.PART3 (PART3),
		.IND   (IND),
		.LOCK  (LOCK),
		.GUARD (GUARD)
	) u_flash (
		.pins (flashPins),
		.dq   (modelDq)
	);

	// Host wins the wire only while it enables its drivers
	assign flashDqIn = flashPins.dqOe ? flashPins.dqOut : modelDq;

	// 125 MHz clock
	always #4 clock = ~clock;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task stopTest();
		if (errorCnt == 0 && nChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Held until the taking edge, then waits on done or refusal
	task automatic doReq(input nfc_op_t o, input logic [23:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		// An edge between calls, so valid never drops and rises at once
		@(posedge clock);
		#1;
		while (reqReady !== 1'b1 && n < 4000)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		reqValid = 1'b1;
		req = {o, a, d};
		@(posedge clock);
		#1;
		reqValid = 1'b0;
		while (reqDone !== 1'b1 && reqError !== 1'b1 && n < 4000)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		gotErr = (reqError === 1'b1);
		chk("finish", 16'(n < 4000), 16'h0001);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clock);
		#1;
		reset_n = 1'b1;
		for (int i = 0; i < N_ROWS; i++)
		begin
			doReq(rows[i].op, rows[i].addr, rows[i].data);
			chk("refused", 16'(gotErr), 16'h0000);
			if (rows[i].op inside {OP_READ, OP_AUTOSELECT})
				chk("readData", readData, rows[i].data);
		end
		// Mode mirrors and refusals
		doReq(OP_OTP_ENTER, 24'h00_0000, 16'h0000);
		chk("inOtp", 16'(inOtp), 16'h0001);
		doReq(OP_READ, 24'h00_0100, 16'h0000);
		chk("otpRange", 16'(gotErr), 16'h0001);
		doReq(OP_OTP_EXIT, 24'h00_0000, 16'h0000);
		chk("inOtp", 16'(inOtp), 16'h0000);
		doReq(OP_BYPASS_ENTER, 24'h00_0000, 16'h0000);
		chk("inBypass", 16'(inBypass), 16'h0001);
		doReq(OP_PROGRAM, 24'h00_2000, 16'h1234);
		chk("longProgram", 16'(gotErr), 16'h0001);
		doReq(OP_BYPASS_EXIT, 24'h00_0000, 16'h0000);
		chk("inBypass", 16'(inBypass), 16'h0000);
		doReq(OP_BYPASS_PROGRAM, 24'h00_2000, 16'h1234);
		chk("shortProgram", 16'(gotErr), 16'h0001);
		doReq(OP_AUTOSELECT, 24'h00_0000, 16'h0000);
		chk("inAutoselect", 16'(inAutoselect), 16'h0001);
		doReq(OP_RESET, 24'h00_0000, 16'h0000);
		chk("inAutoselect", 16'(inAutoselect), 16'h0000);
		// Reset in mid-sequence, then a fresh start
		reqValid = 1'b1;
		req = {OP_PROGRAM, 24'h00_4000, 16'h1234};
		@(posedge clock);
		#1;
		reqValid = 1'b0;
		repeat (20) @(posedge clock);
		#1;
		reset_n = 1'b0;
		#1;
		chk("idleReady", 16'(reqReady), 16'h0001);
		chk("idleStb", 16'({flashPins.weN, flashPins.ceN}), 16'h0003);
		chk("idleRst", 16'({flashPins.resetN, flashPins.oeN}), 16'h0003);
		chk("idleDrive", 16'(flashPins.dqOe), 16'h0000);
		@(posedge clock);
		#1;
		reset_n = 1'b1;
		doReq(OP_RESET, 24'h00_0000, 16'h0000);
		doReq(OP_READ, 24'h00_4000, 16'h0000);
		chk("afterAbort", readData, 16'hFFFF);
		stopTest();
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clock);
		errorCnt++;
		stopTest();
	end
endmodule // test_nfc_host
